/* File: core/spv_host.sv */
// programmer end of the serial program/verify port, with a two-entry read buffer
`timescale 1ns/1ps
`default_nettype none
`include "spv_defs.svh"

module spv_host #(
	parameter int HALF  = `SPV_HALF_CYCLES,
	parameter int ENTRY = `SPV_ENTRY_CYCLES
) (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   nrst,
	// link to the device
	spv_link_if.host                    link,
	// user side mode control
	input  wire logic                   prog_enable,
	output logic                        prog_active,
	// user side commands
	input  wire logic                   cmd_valid,
	output logic                        cmd_ready,
	input  wire logic [`SPV_CMD_W-1:0]  cmd_code,
	input  wire logic [`SPV_DATA_W-1:0] cmd_wdata,
	// user side read words
	output logic                        rd_valid,
	input  wire logic                   rd_ready,
	output logic [`SPV_DATA_W-1:0]      rd_data
);

	// ************************************************************
	// types and storage
	// ************************************************************
	typedef enum logic [6:0] {
		H_OFF   = 7'h01,
		H_SETUP = 7'h02,
		H_WAIT  = 7'h04,
		H_IDLE  = 7'h08,
		H_CMD   = 7'h10,
		H_WR    = 7'h20,
		H_RD    = 7'h40
	} spv_hstate_type;

	spv_hstate_type          state_reg, state_next;
	spv_pkg::spv_kind_type   kind_reg, kind_next;
	logic [15:0]             tmr_reg, tmr_next;
	logic [3:0]              bit_reg, bit_next;
	logic                    ph_reg, ph_next;   // 0 = clock high, 1 = clock low
	logic [`SPV_DATA_W-1:0]  sh_reg, sh_next;
	logic                    clk_reg, clk_next;
	logic                    hv_reg, hv_next;
	logic                    dout_reg, dout_next;
	logic                    doe_reg, doe_next;
	logic                    push;
	logic                    meta_reg, sync_reg;
	logic [`SPV_DATA_W-1:0]  fifo [2];
	logic                    wp_reg, rp_reg;
	logic [1:0]              cnt_reg;
	logic                    fifo_full;
	logic                    last_bit;
	logic                    tmr_done;

	// ************************************************************
	// data pin synchroniser
	// ************************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= link.prog_data_pin;
			sync_reg <= meta_reg;
		end
	end

	assign fifo_full = (cnt_reg == 2'h2);
	assign tmr_done  = (tmr_reg == 16'h0);
	assign last_bit  = (state_reg == H_CMD) ? (bit_reg == `SPV_CMD_CNT_LAST)
	                                        : (bit_reg == `SPV_DATA_CNT_LAST);
	// a read is refused while the buffer is full, so no read word is ever dropped
	assign cmd_ready = (state_reg == H_IDLE) && prog_enable &&
	                   !(fifo_full && spv_pkg::spv_classify(cmd_code) == spv_pkg::SPV_K_READ);

	// ************************************************************
	// entry, clock divider and field shifting
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		kind_next  = kind_reg;
		tmr_next   = tmr_done ? 16'h0 : tmr_reg - 16'h1;
		bit_next   = bit_reg;
		ph_next    = ph_reg;
		sh_next    = sh_reg;
		clk_next   = clk_reg;
		hv_next    = hv_reg;
		dout_next  = dout_reg;
		doe_next   = doe_reg;
		push       = 1'b0;
		unique case (state_reg)
			H_OFF: begin
				if (prog_enable) begin
					state_next = H_SETUP;
					tmr_next   = 16'(ENTRY);
					doe_next   = 1'b1; // hold data low
					dout_next  = 1'b0;
				end
			end
			H_SETUP: begin
				if (tmr_done) begin
					state_next = H_WAIT;
					hv_next    = 1'b1;
					tmr_next   = 16'(ENTRY);
				end
			end
			H_WAIT: begin
				if (tmr_done) begin
					state_next = H_IDLE;
				end
			end
			H_IDLE: begin
				if (!prog_enable) begin
					state_next = H_OFF;
					hv_next    = 1'b0;
					doe_next   = 1'b0;
				end else if (cmd_valid && cmd_ready) begin
					state_next = H_CMD;
					kind_next  = spv_pkg::spv_classify(cmd_code);
					sh_next    = {{(`SPV_DATA_W-`SPV_CMD_W){1'b0}}, cmd_code};
					bit_next   = 4'h0;
					ph_next    = 1'b0;
					clk_next   = 1'b1;
					doe_next   = 1'b1;
					dout_next  = cmd_code[0];
					tmr_next   = 16'(HALF - 1);
				end
			end
			H_CMD, H_WR, H_RD: begin
				if (tmr_done && !ph_reg) begin
					// end of high phase: sample a read bit, then drop the clock
					clk_next = 1'b0;
					ph_next  = 1'b1;
					tmr_next = 16'(HALF - 1);
					if (state_reg == H_RD) begin
						sh_next = {sync_reg, sh_reg[`SPV_DATA_W-1:1]};
					end
					if (state_reg == H_CMD && last_bit && kind_reg == spv_pkg::SPV_K_READ) begin
						doe_next = 1'b0;
					end
				end else if (tmr_done) begin
					ph_next  = 1'b0;
					tmr_next = 16'(HALF - 1);
					if (!last_bit) begin
						bit_next = bit_reg + 4'h1;
						clk_next = 1'b1;
						if (state_reg != H_RD) begin
							sh_next   = {1'b0, sh_reg[`SPV_DATA_W-1:1]};
							dout_next = sh_reg[1];
						end
					end else if (state_reg == H_CMD && kind_reg == spv_pkg::SPV_K_LOAD) begin
						state_next = H_WR;
						sh_next    = cmd_wdata;
						bit_next   = 4'h0;
						clk_next   = 1'b1;
						dout_next  = cmd_wdata[0];
					end else if (state_reg == H_CMD && kind_reg == spv_pkg::SPV_K_READ) begin
						state_next = H_RD;
						bit_next   = 4'h0;
						clk_next   = 1'b1;
					end else begin
						state_next = H_IDLE;
						push       = (state_reg == H_RD);
						doe_next   = 1'b1;
						dout_next  = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= H_OFF;
			kind_reg  <= spv_pkg::SPV_K_OTHER;
			tmr_reg   <= 16'h0;
			bit_reg   <= 4'h0;
			ph_reg    <= 1'b0;
			sh_reg    <= '0;
			clk_reg   <= 1'b0;
			hv_reg    <= 1'b0;
			dout_reg  <= 1'b0;
			doe_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			kind_reg  <= kind_next;
			tmr_reg   <= tmr_next;
			bit_reg   <= bit_next;
			ph_reg    <= ph_next;
			sh_reg    <= sh_next;
			clk_reg   <= clk_next;
			hv_reg    <= hv_next;
			dout_reg  <= dout_next;
			doe_reg   <= doe_next;
		end
	end

	// ************************************************************
	// two-entry read buffer
	// ************************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wp_reg  <= 1'b0;
			rp_reg  <= 1'b0;
			cnt_reg <= 2'h0;
			fifo[0] <= '0;
			fifo[1] <= '0;
		end else begin
			if (push) begin
				fifo[wp_reg] <= sh_reg;
				wp_reg       <= ~wp_reg;
			end
			if (rd_valid && rd_ready) begin
				rp_reg <= ~rp_reg;
			end
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, rd_valid && rd_ready};
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign rd_valid              = (cnt_reg != 2'h0);
	assign rd_data               = fifo[rp_reg];
	assign prog_active           = hv_reg;
	assign link.prog_clock_pin   = clk_reg;
	assign link.master_clear_pin = hv_reg;
	assign link.host_data_out    = dout_reg;
	assign link.host_data_oe     = doe_reg;

endmodule

`default_nettype wire

/* File: core/spv_defs.svh */
// constants for the serial program/verify port: widths, command codes, timing
`ifndef SPV_DEFS_SVH
`define SPV_DEFS_SVH

// field widths
`define SPV_CMD_W          6
`define SPV_DATA_W         14
`define SPV_CMD_CNT_LAST   4'h5
`define SPV_DATA_CNT_LAST  4'hd
// command codes
`define SPV_CMD_LOAD       6'h02
`define SPV_CMD_READ       6'h04
`define SPV_CMD_INCR       6'h06
// pointer value on mode entry
`define SPV_RESET_ADDR     10'h000
// timing: system clock, link clock, entry settle time
`define SPV_CLK_PERIOD_NS  50
`define SPV_LINK_PERIOD_NS 400
`define SPV_ENTRY_NS       5000
`define SPV_HALF_CYCLES    ((`SPV_LINK_PERIOD_NS / 2) / `SPV_CLK_PERIOD_NS)
`define SPV_ENTRY_CYCLES   ((`SPV_ENTRY_NS + `SPV_CLK_PERIOD_NS - 1) / `SPV_CLK_PERIOD_NS)

`endif

/* File: core/spv_pkg.sv */
// types and command decoding shared by both ends of the program/verify port
`include "spv_defs.svh"

package spv_pkg;

	// what a command word asks for
	typedef enum logic [1:0] {
		SPV_K_OTHER = 2'h0,
		SPV_K_LOAD  = 2'h1,
		SPV_K_READ  = 2'h2,
		SPV_K_INCR  = 2'h3
	} spv_kind_type;

	// decoding used by device and host alike
	function automatic spv_kind_type spv_classify(input logic [`SPV_CMD_W-1:0] code);
		spv_kind_type k;
		k = SPV_K_OTHER;
		if (code == `SPV_CMD_LOAD) begin
			k = SPV_K_LOAD;
		end else if (code == `SPV_CMD_READ) begin
			k = SPV_K_READ;
		end else if (code == `SPV_CMD_INCR) begin
			k = SPV_K_INCR;
		end
		return k;
	endfunction

endpackage

/* File: core/spv_link_if.sv */
// two-wire program/verify link plus the master clear level, with data line resolution
`timescale 1ns/1ps
`default_nettype none

interface spv_link_if;
	logic prog_clock_pin;   // driven by the host only
	logic master_clear_pin; // 1 = pin at high_programming_level
	logic host_data_out;
	logic host_data_oe;
	logic dev_data_out;
	logic dev_data_oe;
	logic prog_data_pin;    // resolved wire level

	// host wins a clash; an undriven line is pulled low
	assign prog_data_pin = host_data_oe ? host_data_out :
	                       (dev_data_oe ? dev_data_out : 1'b0);

	modport host (
		output prog_clock_pin,
		output master_clear_pin,
		output host_data_out,
		output host_data_oe,
		input  prog_data_pin
	);

	modport device (
		input  prog_clock_pin,
		input  master_clear_pin,
		input  prog_data_pin,
		output dev_data_out,
		output dev_data_oe
	);
endinterface

`default_nettype wire

/* File: core/spv_device.sv */
// device end of the serial program/verify port with its program memory
`timescale 1ns/1ps
`default_nettype none
`include "spv_defs.svh"

module spv_device #(
	parameter int ADDR_W = 10,
	parameter int DEPTH  = 1024
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// link to the programmer
	spv_link_if.device             link,
	// user side status
	output logic                   prog_mode,
	output logic [ADDR_W-1:0]      prog_addr,
	output logic                   word_written,
	// user side memory inspection
	input  wire logic [ADDR_W-1:0] peek_addr,
	output logic [`SPV_DATA_W-1:0] peek_data
);

	// ************************************************************
	// types and storage
	// ************************************************************
	typedef enum logic [3:0] {
		D_OFF  = 4'h1,
		D_CMD  = 4'h2,
		D_LOAD = 4'h4,
		D_READ = 4'h8
	} spv_dstate_type;

	logic [`SPV_DATA_W-1:0] mem [DEPTH];

	logic [2:0]              meta_reg;
	logic [2:0]              sync_reg;
	logic                    clk_prev_reg;
	logic                    hv_prev_reg;
	logic                    pin_clk;
	logic                    pin_dat;
	logic                    pin_hv;
	logic                    fall;
	logic                    hv_rise;
	logic [`SPV_DATA_W-1:0]  mem_word;

	spv_dstate_type          state_reg;
	spv_dstate_type          state_next;
	logic [3:0]              cnt_reg;
	logic [3:0]              cnt_next;
	logic [`SPV_CMD_W-1:0]   cmd_reg;
	logic [`SPV_CMD_W-1:0]   cmd_next;
	logic [`SPV_DATA_W-1:0]  shift_reg;
	logic [`SPV_DATA_W-1:0]  shift_next;
	logic [ADDR_W-1:0]       pc_reg;
	logic [ADDR_W-1:0]       pc_next;
	logic                    dout_reg;
	logic                    dout_next;
	logic                    doe_reg;
	logic                    doe_next;
	logic                    wr_reg;
	logic                    wr_next;
	logic [`SPV_DATA_W-1:0]  peek_reg;

	// ************************************************************
	// pin synchronisers and edge detection
	// ************************************************************
	// the link clock is a pin like any other, so it is sampled, never used as a clock
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_reg     <= 3'h0;
			sync_reg     <= 3'h0;
			clk_prev_reg <= 1'b0;
			hv_prev_reg  <= 1'b0;
		end else begin
			meta_reg     <= {link.master_clear_pin, link.prog_data_pin, link.prog_clock_pin};
			sync_reg     <= meta_reg;
			clk_prev_reg <= sync_reg[0];
			hv_prev_reg  <= sync_reg[2];
		end
	end

	assign pin_clk  = sync_reg[0];
	assign pin_dat  = sync_reg[1];
	assign pin_hv   = sync_reg[2];
	assign fall     = clk_prev_reg & ~pin_clk;
	assign hv_rise  = pin_hv & ~hv_prev_reg;
	assign mem_word = mem[pc_reg];

	// ************************************************************
	// command, load and read sequencing
	// ************************************************************
	// dropping the high level aborts any field at once and frees the data line
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		cmd_next   = cmd_reg;
		shift_next = shift_reg;
		pc_next    = pc_reg;
		dout_next  = dout_reg;
		doe_next   = doe_reg;
		wr_next    = 1'b0;
		if (!pin_hv) begin
			state_next = D_OFF;
			cnt_next   = 4'h0;
			doe_next   = 1'b0;
		end else begin
			unique case (state_reg)
				D_OFF: begin
					// entry only on the rising high level with both pins low
					if (hv_rise && !pin_clk && !pin_dat) begin
						state_next = D_CMD;
						cnt_next   = 4'h0;
						pc_next    = ADDR_W'(`SPV_RESET_ADDR);
					end
				end
				D_CMD: begin
					if (fall) begin
						cmd_next = {pin_dat, cmd_reg[`SPV_CMD_W-1:1]};
						cnt_next = cnt_reg + 4'h1;
						if (cnt_reg == `SPV_CMD_CNT_LAST) begin
							cnt_next = 4'h0;
							unique case (spv_pkg::spv_classify(cmd_next))
								spv_pkg::SPV_K_LOAD: begin
									state_next = D_LOAD;
								end
								spv_pkg::SPV_K_READ: begin
									// take the line right after the command field ends
									state_next = D_READ;
									shift_next = mem_word;
									dout_next  = mem_word[0];
									doe_next   = 1'b1;
								end
								spv_pkg::SPV_K_INCR: begin
									pc_next = pc_reg + 1'b1;
								end
								spv_pkg::SPV_K_OTHER: begin
									// unknown commands are ignored
									state_next = D_CMD;
								end
							endcase
						end
					end
				end
				D_LOAD: begin
					if (fall) begin
						shift_next = {pin_dat, shift_reg[`SPV_DATA_W-1:1]};
						cnt_next   = cnt_reg + 4'h1;
						if (cnt_reg == `SPV_DATA_CNT_LAST) begin
							cnt_next   = 4'h0;
							state_next = D_CMD;
							wr_next    = 1'b1;
						end
					end
				end
				D_READ: begin
					// next bit is set up after each falling edge, stable over the next high phase
					if (fall) begin
						shift_next = {1'b0, shift_reg[`SPV_DATA_W-1:1]};
						dout_next  = shift_reg[1];
						cnt_next   = cnt_reg + 4'h1;
						if (cnt_reg == `SPV_DATA_CNT_LAST) begin
							cnt_next   = 4'h0;
							state_next = D_CMD;
							doe_next   = 1'b0;
							dout_next  = 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= D_OFF;
			cnt_reg   <= 4'h0;
			cmd_reg   <= '0;
			shift_reg <= '0;
			pc_reg    <= '0;
			dout_reg  <= 1'b0;
			doe_reg   <= 1'b0;
			wr_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			cmd_reg   <= cmd_next;
			shift_reg <= shift_next;
			pc_reg    <= pc_next;
			dout_reg  <= dout_next;
			doe_reg   <= doe_next;
			wr_reg    <= wr_next;
		end
	end

	// ************************************************************
	// program memory
	// ************************************************************
	// written the cycle after the last data bit; the pointer cannot move that soon
	always_ff @(posedge mclk) begin
		if (wr_reg) begin
			mem[pc_reg] <= shift_reg;
		end
	end

	// inspection port, one cycle of latency
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			peek_reg <= '0;
		end else begin
			peek_reg <= mem[peek_addr];
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign link.dev_data_out = dout_reg;
	assign link.dev_data_oe  = doe_reg;
	assign prog_mode         = (state_reg != D_OFF);
	assign prog_addr         = pc_reg;
	assign word_written      = wr_reg;
	assign peek_data         = peek_reg;

endmodule

`default_nettype wire

/* File: dv/spv_chk.sv */
// checker of the link wires between the host and device ends
`timescale 1ns/1ps
`default_nettype none

module spv_chk #(
	parameter int HALF = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// link wires
	input wire logic prog_clock_pin,
	input wire logic master_clear_pin,
	input wire logic host_data_out,
	input wire logic host_data_oe,
	input wire logic dev_data_out,
	input wire logic dev_data_oe,
	input wire logic prog_data_pin
);
	// ************
	// helper logic
	// ************
	logic       clk_d_reg;
	logic       clk_d_next;
	logic [4:0] fall_cnt_reg;
	logic [4:0] fall_cnt_next;

	// link clock falls seen while the device drives the line
	always_comb begin
		clk_d_next = prog_clock_pin;
		fall_cnt_next = fall_cnt_reg;
		if (!dev_data_oe) begin
			fall_cnt_next = 5'h00;
		end else if (clk_d_reg && !prog_clock_pin) begin
			fall_cnt_next = fall_cnt_reg + 5'h01;
		end
	end

	// registers only
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			clk_d_reg <= 1'b0;
			fall_cnt_reg <= 5'h00;
		end else begin
			clk_d_reg <= clk_d_next;
			fall_cnt_reg <= fall_cnt_next;
		end
	end

	// **********
	// assertions
	// **********
	chk_one_driver: assert property (@(posedge mclk) disable iff (!nrst)
		!(host_data_oe && dev_data_oe)) else $error("both ends drive data");
	chk_entry_quiet: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(master_clear_pin) |-> !prog_clock_pin && !prog_data_pin)
		else $error("mode entry with clock or data high");
	chk_idle_release: assert property (@(posedge mclk) disable iff (!nrst)
		!master_clear_pin [*5] |-> !dev_data_oe) else $error("device drives out of mode");
	// an abort may cut a high phase short, so mode loss disables this one
	chk_clock_high: assert property (@(posedge mclk)
		disable iff (!nrst || !master_clear_pin)
		$rose(prog_clock_pin) |-> ##HALF $fell(prog_clock_pin))
		else $error("clock high phase length wrong");
	chk_host_hold: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(prog_clock_pin) && host_data_oe |-> $stable(host_data_out))
		else $error("host data moved at sampling edge");
	chk_dev_hold: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(prog_clock_pin) && dev_data_oe |-> $stable(dev_data_out))
		else $error("device data moved at sampling edge");
	chk_read_width: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(dev_data_oe) && master_clear_pin |-> fall_cnt_reg == 5'h0e)
		else $error("read word not fourteen bits");
	chk_turn_gap: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(dev_data_oe) |-> !$past(host_data_oe, 2))
		else $error("device drives before host released");
endmodule

`default_nettype wire

/* File: dv/spv_tb_top.sv */
// testbench joining host and device ends across the link
`timescale 1ns/1ps
`default_nettype none
`include "spv_defs.svh"

module spv_tb_top;
	localparam int AW = 4;
	logic                   mclk;
	logic                   nrst;
	logic                   prog_enable;
	logic                   prog_active;
	logic                   cmd_valid;
	logic                   cmd_ready;
	logic [`SPV_CMD_W-1:0]  cmd_code;
	logic [`SPV_DATA_W-1:0] cmd_wdata;
	logic                   rd_valid;
	logic                   rd_ready;
	logic [`SPV_DATA_W-1:0] rd_data;
	logic                   prog_mode;
	logic [AW-1:0]          prog_addr;
	logic                   word_written;
	logic [AW-1:0]          peek_addr;
	logic [`SPV_DATA_W-1:0] peek_data;
	logic [31:0]            seed;
	logic [`SPV_DATA_W-1:0] exp_mem [16];
	logic [`SPV_DATA_W-1:0] w;
	logic                   ok;
	int                     failures;
	int                     comparisons;
	int                     writes;

	// ***********
	// environment
	// ***********
	spv_link_if u_spv_link_if ();
	spv_host #(.HALF(4), .ENTRY(20)) u_spv_host (.mclk(mclk), .nrst(nrst),
		.link(u_spv_link_if), .prog_enable(prog_enable), .prog_active(prog_active),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
	// small memory so the pointer wrap is cheap to reach
	spv_device #(.ADDR_W(AW), .DEPTH(16)) u_spv_device (.mclk(mclk), .nrst(nrst),
		.link(u_spv_link_if), .prog_mode(prog_mode), .prog_addr(prog_addr),
		.word_written(word_written), .peek_addr(peek_addr), .peek_data(peek_data));
	spv_chk #(.HALF(4)) u_spv_chk (.mclk(mclk), .nrst(nrst),
		.prog_clock_pin(u_spv_link_if.prog_clock_pin),
		.master_clear_pin(u_spv_link_if.master_clear_pin),
		.host_data_out(u_spv_link_if.host_data_out),
		.host_data_oe(u_spv_link_if.host_data_oe),
		.dev_data_out(u_spv_link_if.dev_data_out),
		.dev_data_oe(u_spv_link_if.dev_data_oe),
		.prog_data_pin(u_spv_link_if.prog_data_pin));

	// 20 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// count memory write pulses
	always @(posedge mclk) begin
		if (word_written === 1'b1) writes++;
	end

	// *************
	// bench helpers
	// *************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t: saw %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// hold the request until it is taken or the limit runs out
	task automatic send(input logic [5:0] code, input logic [13:0] wd, input int lim,
		output logic acc);
		int n;
		acc = 1'b0;
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_wdata <= wd;
		for (n = 0; n < lim; n++) begin
			@(posedge mclk);
			if (cmd_ready === 1'b1) begin
				acc = 1'b1;
				break;
			end
		end
		cmd_valid <= 1'b0;
	endtask

	// ready comes back once the link is idle again
	task automatic wait_ready;
		int n;
		@(posedge mclk);
		for (n = 0; n < 2000; n++) begin
			@(posedge mclk);
			if (cmd_ready === 1'b1) break;
		end
		if (n == 2000) begin
			failures++;
			$display("BAD %0t: link never returned to idle", $time);
		end
	endtask

	task automatic run(input logic [5:0] code, input logic [13:0] wd);
		send(code, wd, 2000, ok);
		if (ok !== 1'b1) begin
			failures++;
			$display("BAD %0t: command never taken", $time);
		end
		wait_ready();
	endtask

	task automatic enter;
		@(posedge mclk);
		prog_enable <= 1'b1;
		wait_ready();
	endtask

	task automatic leave;
		int n;
		@(posedge mclk);
		prog_enable <= 1'b0;
		for (n = 0; n < 200 && prog_active !== 1'b0; n++) @(posedge mclk);
		repeat (8) @(posedge mclk);
	endtask

	// take n words with the consumer ready and compare them in order
	task automatic drain(input int n, input int base);
		int k;
		int t;
		k = 0;
		@(posedge mclk);
		rd_ready <= 1'b1;
		for (t = 0; t < 3000 && k < n; t++) begin
			@(posedge mclk);
			if (rd_valid === 1'b1) begin
				check(16'(rd_data), 16'(exp_mem[base + k]));
				k++;
			end
		end
		rd_ready <= 1'b0;
		check(k[15:0], n[15:0]);
	endtask

	// ********
	// sequence
	// ********
	initial begin
		nrst = 1'b0;
		prog_enable = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = 6'h00;
		cmd_wdata = 14'h0000;
		rd_ready = 1'b0;
		peek_addr = 4'h0;
		seed = 32'h1f82;
		failures = 0;
		comparisons = 0;
		writes = 0;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		check(16'(prog_mode), 16'h0000);
		enter();
		check(16'(prog_active), 16'h0001);
		check(16'(prog_mode), 16'h0001);
		check(16'(prog_addr), 16'h0000);
		$display("test entry done");
		// foreign codes move neither pointer nor memory
		run(6'h00, 14'h1234);
		run(6'h01, 14'h2222);
		run(6'h3f, 14'h0f0f);
		run(6'h03, 14'h3333);
		check(16'(prog_addr), 16'h0000);
		check(writes[15:0], 16'h0000);
		$display("test foreign codes done");
		// fill every word, corners first, and wrap the pointer
		for (int i = 0; i < 16; i++) begin
			seed = lfsr_next(seed);
			w = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3fff : (i == 2) ? 14'h2aaa : seed[13:0];
			exp_mem[i] = w;
			run(`SPV_CMD_LOAD, w);
			run(`SPV_CMD_INCR, 14'h0000);
			check(16'(prog_addr), 16'((i + 1) % 16));
		end
		check(writes[15:0], 16'h0010);
		for (int i = 0; i < 16; i++) begin
			@(posedge mclk);
			peek_addr <= 4'(i);
			repeat (2) @(posedge mclk);
			check(16'(peek_data), 16'(exp_mem[i]));
		end
		$display("test load done");
		// move the pointer off zero so that re-entry has something to reset
		run(`SPV_CMD_INCR, 14'h0000);
		check(16'(prog_addr), 16'h0001);
		leave();
		check(16'(prog_mode), 16'h0000);
		check(16'(prog_active), 16'h0000);
		enter();
		check(16'(prog_addr), 16'h0000);
		$display("test reentry done");
		// stalled consumer: two words buffered, a third read is refused
		run(`SPV_CMD_READ, 14'h0000);
		run(`SPV_CMD_INCR, 14'h0000);
		send(`SPV_CMD_READ, 14'h0000, 2000, ok);
		run(`SPV_CMD_INCR, 14'h0000);
		send(`SPV_CMD_READ, 14'h0000, 400, ok);
		check(16'(ok), 16'h0000);
		drain(2, 0);
		run(`SPV_CMD_READ, 14'h0000);
		drain(1, 2);
		for (int i = 3; i < 15; i += 2) begin
			run(`SPV_CMD_INCR, 14'h0000);
			run(`SPV_CMD_READ, 14'h0000);
			run(`SPV_CMD_INCR, 14'h0000);
			send(`SPV_CMD_READ, 14'h0000, 2000, ok);
			drain(2, i);
		end
		$display("test read done");
		complete_run();
	end

	// watchdog well past the expected run length
	initial begin
		repeat (40000) @(posedge mclk);
		failures++;
		$display("BAD %0t: run did not finish", $time);
		complete_run();
	end
endmodule

`default_nettype wire
